/* verilog/acxr_pkg.sv */
// Constants for the calibration, excitation and GPIO register bank.
// Assumes byte addressing on a 32-bit AXI4-Lite bus, one register per word.
`default_nettype none
package acxr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_COEF_LO = 6'h07;
  localparam logic [5:0] IDX_COEF_MID = 6'h08;
  localparam logic [5:0] IDX_COEF_HI = 6'h09;
  localparam logic [5:0] IDX_EXC_CTRL = 6'h0A;
  localparam logic [5:0] IDX_EXC_ROUTE = 6'h0B;
  localparam logic [5:0] IDX_GPIO_EN = 6'h0C;
  localparam logic [5:0] IDX_GPIO_DIR = 6'h0D;
  localparam logic [5:0] IDX_GPIO_DATA = 6'h0E;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_COEF_HI = {IDX_COEF_HI, 2'h0};
  localparam logic [7:0] ADDR_EXC_CTRL = {IDX_EXC_CTRL, 2'h0};
  // Reset values
  localparam logic [23:0] COEF_RESET = 24'h400000;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] ROUTE_RESET = 8'hFF;
  localparam logic [7:0] GPIO_RESET = 8'h00;
  // Field positions
  localparam int MODE_BIT = 3;
  localparam int REV_LSB = 4;
  localparam int COEF_SHIFT = 22;
  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Current magnitudes in microamps
  localparam logic [10:0] UA_OFF = 11'h000;
  localparam logic [10:0] UA_50 = 11'h032;
  localparam logic [10:0] UA_100 = 11'h064;
  localparam logic [10:0] UA_250 = 11'h0FA;
  localparam logic [10:0] UA_500 = 11'h1F4;
  localparam logic [10:0] UA_750 = 11'h2EE;
  localparam logic [10:0] UA_1500 = 11'h5DC;
  // Route vector layout: bits 7..0 analog inputs, then the two pins
  localparam int ROUTE_EXC1 = 8;
  localparam int ROUTE_EXC2 = 9;
endpackage
`default_nettype wire

/* verilog/acxr_regs.sv */
// Calibration, excitation-current and GPIO register bank with result scaling.
// Assumes an AXI4-Lite master, conversion results on the same clock, async pins.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acxr_regs #(
  parameter logic [3:0] REVISION = 4'hA // Arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [acxr_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [acxr_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_result_valid,
  input wire logic [23:0] i_raw_result,
  input wire logic [23:0] i_offset_coeff,
  input wire logic i_result_read,
  input wire logic i_serial_dout,
  input wire logic i_serial_active,
  output logic [23:0] o_scaled_result,
  output logic o_scaled_valid,
  output logic o_data_ready_n,
  output logic o_shared_data_out,
  output logic [2:0] o_current_magnitude,
  output logic [10:0] o_current_ua,
  output logic [9:0] o_first_source_route,
  output logic [9:0] o_second_source_route,
  input wire logic [7:0] i_gpio_in,
  output logic [7:0] o_gpio_out,
  output logic [7:0] o_gpio_oe
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [5:0] awidx;
    logic [7:0] wbyte;
    logic wlane0;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [23:0] coef;
    logic [3:0] ctrl_low;
    logic [7:0] route;
    logic [7:0] gpio_en;
    logic [7:0] gpio_dir;
    logic [7:0] gpio_dat;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic sub_v;
    logic [23:0] sub;
    logic res_v;
    logic [23:0] result;
    logic rdy_n;
    logic shared;
    logic [10:0] cur_ua;
    logic [9:0] src1;
    logic [9:0] src2;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
  } acxr_state_t;

  acxr_state_t q;
  acxr_state_t d;
  logic rst_meta_n;
  logic rst_n;
  logic signed [26:0] diff;
  logic signed [48:0] prod;

  // Two-stage release keeps reset removal synchronous to i_clock
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  function automatic logic [23:0] sat24(input logic signed [26:0] v);
    if (v > 27'sh07FFFFF) begin
      sat24 = 24'h7FFFFF;
    end else if (v < -27'sh0800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  function automatic logic [10:0] mag_ua(input logic [2:0] code);
    case (code)
      3'h1: mag_ua = acxr_pkg::UA_50;
      3'h2: mag_ua = acxr_pkg::UA_100;
      3'h3: mag_ua = acxr_pkg::UA_250;
      3'h4: mag_ua = acxr_pkg::UA_500;
      3'h5: mag_ua = acxr_pkg::UA_750;
      3'h7: mag_ua = acxr_pkg::UA_1500;
      // Code 6 has no defined current; treated as off
      default: mag_ua = acxr_pkg::UA_OFF;
    endcase
  endfunction

  function automatic logic [9:0] route_of(input logic [3:0] sel);
    route_of = 10'h000;
    if (!sel[3]) begin
      route_of[sel[2:0]] = 1'b1;
    end else if (!sel[2]) begin
      if (sel[0]) begin
        route_of[acxr_pkg::ROUTE_EXC2] = 1'b1;
      end else begin
        route_of[acxr_pkg::ROUTE_EXC1] = 1'b1;
      end
    end
  endfunction

  // Enabled inputs read the pin, everything else the stored bit
  function automatic logic [7:0] read_byte(input acxr_state_t s, input logic [5:0] idx, output logic hit);
    hit = 1'b1;
    case (idx)
      acxr_pkg::IDX_COEF_LO: read_byte = s.coef[7:0];
      acxr_pkg::IDX_COEF_MID: read_byte = s.coef[15:8];
      acxr_pkg::IDX_COEF_HI: read_byte = s.coef[23:16];
      acxr_pkg::IDX_EXC_CTRL: read_byte = {REVISION, s.ctrl_low};
      acxr_pkg::IDX_EXC_ROUTE: read_byte = s.route;
      acxr_pkg::IDX_GPIO_EN: read_byte = s.gpio_en;
      acxr_pkg::IDX_GPIO_DIR: read_byte = s.gpio_dir;
      acxr_pkg::IDX_GPIO_DATA: read_byte = (s.gpio_en & s.gpio_dir & s.pin_sync) | (~(s.gpio_en & s.gpio_dir) & s.gpio_dat);
      default: begin
        read_byte = 8'h00;
        hit = 1'b0;
      end
    endcase
  endfunction

  always_comb begin
    logic hit;
    logic [7:0] rbyte;
    hit = 1'b0;
    rbyte = 8'h00;
    d = q;
    diff = 27'(signed'(i_raw_result)) - 27'(signed'(i_offset_coeff));
    prod = $signed(q.sub) * $signed({1'b0, q.coef});
    d.pin_meta = i_gpio_in;
    d.pin_sync = q.pin_meta;
    // Write address and data taken independently, either order
    if (i_s_axi_awvalid && q.awready) begin
      d.awidx = i_s_axi_awaddr[7:2];
      d.awready = 1'b0;
    end
    if (i_s_axi_wvalid && q.wready) begin
      d.wbyte = i_s_axi_wdata[7:0];
      d.wlane0 = i_s_axi_wstrb[0];
      d.wready = 1'b0;
    end
    if (!q.awready && !q.wready && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp = acxr_pkg::RESP_OKAY;
      case (q.awidx)
        acxr_pkg::IDX_COEF_LO: if (q.wlane0) d.coef[7:0] = q.wbyte;
        acxr_pkg::IDX_COEF_MID: if (q.wlane0) d.coef[15:8] = q.wbyte;
        acxr_pkg::IDX_COEF_HI: if (q.wlane0) d.coef[23:16] = q.wbyte;
        acxr_pkg::IDX_EXC_CTRL: if (q.wlane0) d.ctrl_low = q.wbyte[3:0];
        acxr_pkg::IDX_EXC_ROUTE: if (q.wlane0) d.route = q.wbyte;
        acxr_pkg::IDX_GPIO_EN: if (q.wlane0) d.gpio_en = q.wbyte;
        acxr_pkg::IDX_GPIO_DIR: if (q.wlane0) d.gpio_dir = q.wbyte;
        acxr_pkg::IDX_GPIO_DATA: if (q.wlane0) d.gpio_dat = q.wbyte;
        default: d.bresp = acxr_pkg::RESP_SLVERR;
      endcase
    end
    if (q.bvalid && i_s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (i_s_axi_arvalid && q.arready) begin
      rbyte = read_byte(q, i_s_axi_araddr[7:2], hit);
      d.rdata = {24'h000000, rbyte};
      d.rresp = hit ? acxr_pkg::RESP_OKAY : acxr_pkg::RESP_SLVERR;
      d.rvalid = 1'b1;
      d.arready = 1'b0;
    end
    if (q.rvalid && i_s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    // Offset first, then scale; the 22-bit shift keeps unity scaling exact
    d.sub_v = i_result_valid;
    if (i_result_valid) begin
      d.sub = sat24(diff);
    end
    d.res_v = q.sub_v;
    if (q.sub_v) begin
      d.result = sat24(prod[acxr_pkg::COEF_SHIFT+26:acxr_pkg::COEF_SHIFT]);
    end
    // New result wins over a same-cycle read acknowledge
    if (i_result_read) begin
      d.rdy_n = 1'b1;
    end
    if (q.res_v) begin
      d.rdy_n = 1'b0;
    end
    // Ready shown only while no word is shifting out
    d.shared = (q.ctrl_low[acxr_pkg::MODE_BIT] && !i_serial_active) ? q.rdy_n : i_serial_dout;
    d.cur_ua = mag_ua(q.ctrl_low[2:0]);
    d.src1 = route_of(q.route[7:4]);
    d.src2 = route_of(q.route[3:0]);
    d.gpio_oe = q.gpio_en & ~q.gpio_dir;
    d.gpio_out = q.gpio_dat;
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.coef <= acxr_pkg::COEF_RESET;
      q.ctrl_low <= acxr_pkg::CTRL_RESET;
      q.route <= acxr_pkg::ROUTE_RESET;
      q.gpio_en <= acxr_pkg::GPIO_RESET;
      q.gpio_dir <= acxr_pkg::GPIO_RESET;
      q.gpio_dat <= acxr_pkg::GPIO_RESET;
      q.rdy_n <= 1'b1;
      q.shared <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_s_axi_awready = q.awready;
  assign o_s_axi_wready = q.wready;
  assign o_s_axi_bvalid = q.bvalid;
  assign o_s_axi_bresp = q.bresp;
  assign o_s_axi_arready = q.arready;
  assign o_s_axi_rvalid = q.rvalid;
  assign o_s_axi_rdata = q.rdata;
  assign o_s_axi_rresp = q.rresp;
  assign o_scaled_result = q.result;
  assign o_scaled_valid = q.res_v;
  assign o_data_ready_n = q.rdy_n;
  assign o_shared_data_out = q.shared;
  assign o_current_magnitude = q.ctrl_low[2:0];
  assign o_current_ua = q.cur_ua;
  assign o_first_source_route = q.src1;
  assign o_second_source_route = q.src2;
  assign o_gpio_out = q.gpio_out;
  assign o_gpio_oe = q.gpio_oe;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  revision_read_a: assert property ((i_s_axi_arvalid && o_s_axi_arready
    && i_s_axi_araddr == acxr_pkg::ADDR_EXC_CTRL) |=> o_s_axi_rdata[7:acxr_pkg::REV_LSB] == REVISION)
    else $error("revision field not read back");
  unity_scale_a: assert property ((q.sub_v && q.coef == acxr_pkg::COEF_RESET)
    |=> o_scaled_result == $past(q.sub)) else $error("unity coefficient altered result");
  // Small positive operands only, so no saturation hides the subtraction
  offset_first_a: assert property ((i_result_valid && i_raw_result[23:20] == 4'h0
    && i_offset_coeff[23:20] == 4'h0) |=> q.sub == $past(i_raw_result - i_offset_coeff))
    else $error("offset stage wrong");
  // Pin falls one edge after the result pulse
  ready_pin_a: assert property (o_scaled_valid |=> !o_data_ready_n)
    else $error("ready pin not low after result");
  // Sampled reset keeps the reset-release edge out
  shared_pin_a: assert property ((rst_n && !q.ctrl_low[acxr_pkg::MODE_BIT])
    |=> o_shared_data_out == $past(i_serial_dout)) else $error("shared pin not pure data out");
  magnitude_map_a: assert property ((q.ctrl_low[2:0] == 3'h4) |=> o_current_ua == acxr_pkg::UA_500)
    else $error("magnitude code 4 wrong");
  first_off_a: assert property ((q.route[7:6] == 2'h3) |=> o_first_source_route == 10'h000)
    else $error("first source not disconnected");
  second_pin_a: assert property ((q.route[3:0] == 4'hB) |=> o_second_source_route == 10'h200)
    else $error("second source pin 2 routing wrong");
  input_no_drive_a: assert property ((q.gpio_dir[0] || !q.gpio_en[0]) |=> !o_gpio_oe[0])
    else $error("input gpio driven");
  coef_byte_a: assert property ((i_s_axi_arvalid && o_s_axi_arready
    && i_s_axi_araddr == acxr_pkg::ADDR_COEF_HI) |=> o_s_axi_rdata == {24'h000000, $past(q.coef[23:16])})
    else $error("coefficient high byte wrong");

endmodule // acxr_regs
`default_nettype wire

/* verif/acxr_pin_model.sv */
// Pad model for the eight GPIO pins of the register bank.
// Assumes an outside driver that yields wherever the bank drives.
`timescale 1ns/1ps
`default_nettype none
module acxr_pin_model (
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_level
);
  // Bank wins where it drives, the outside elsewhere
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext);
endmodule // acxr_pin_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the register bank over AXI4-Lite.
// Assumes the bank package and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value
  logic clk, rst_n, awv, wv, bre, arv, rre, rvld, rrel, sdo, sact;
  logic awr, wrdy, bv, arr, rv, sv, rdy_n, shr;
  logic [7:0] awa, ara, ext, lvl, gout, goe;
  logic [31:0] wd, rdat;
  logic [23:0] raw, ofs, sres;
  logic [1:0] br, rr;
  logic [2:0] mag;
  logic [10:0] ua;
  logic [9:0] r1, r2;
  logic [10:0] uat [8];
  logic [7:0] codes [4];
  int bad_count, cmp_count;
  acxr_regs #(.REVISION(REV)) i_dut (.i_clock(clk), .i_arst_n(rst_n),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bre), .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rr), .i_result_valid(rvld), .i_raw_result(raw), .i_offset_coeff(ofs),
    .i_result_read(rrel), .i_serial_dout(sdo), .i_serial_active(sact), .o_scaled_result(sres),
    .o_scaled_valid(sv), .o_data_ready_n(rdy_n), .o_shared_data_out(shr), .o_current_magnitude(mag),
    .o_current_ua(ua), .o_first_source_route(r1), .o_second_source_route(r2), .i_gpio_in(lvl),
    .o_gpio_out(gout), .o_gpio_oe(goe));
  acxr_pin_model i_pins (.i_oe(goe), .i_out(gout), .i_ext(ext), .o_level(lvl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out;
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = acxr_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= {idx, 2'h0};
    wv <= 1'b1;
    wd <= {24'h0, d};
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      n++;
    end while (!bv && n < 40);
    bre <= 1'b0;
    if (n >= 40) bad_count++;
    chk("bresp", {30'h0, er}, {30'h0, br});
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er = acxr_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= {idx, 2'h0};
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 40);
    rre <= 1'b0;
    if (n >= 40) bad_count++;
    chk("rdata", {24'h0, e}, rdat);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask
  // Result goes in, scaled value and ready pin come out
  task automatic res(input logic [23:0] a, input logic [23:0] b, input logic [23:0] e);
    int n;
    n = 0;
    @(posedge clk);
    rvld <= 1'b1;
    raw <= a;
    ofs <= b;
    @(posedge clk);
    rvld <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!sv && n < 10);
    if (n >= 10) bad_count++;
    chk("scaled", {8'h0, e}, {8'h0, sres});
    #1;
    chk("ready_n", 32'h0, {31'h0, rdy_n});
  endtask
  function automatic logic [9:0] route(input logic [3:0] c);
    if (!c[3]) return 10'h001 << c[2:0];
    if (!c[2]) return c[0] ? 10'h200 : 10'h100;
    return 10'h000;
  endfunction
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    {awv, wv, bre, arv, rre, rvld, rrel, sdo, sact} = '0;
    {awa, ara, wd, raw, ofs} = '0;
    ext = 8'h3C;
    rst_n = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    uat = '{acxr_pkg::UA_OFF, acxr_pkg::UA_50, acxr_pkg::UA_100, acxr_pkg::UA_250,
      acxr_pkg::UA_500, acxr_pkg::UA_750, acxr_pkg::UA_OFF, acxr_pkg::UA_1500};
    codes = '{8'h07, 8'h9A, 8'hAB, 8'hEC};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(acxr_pkg::IDX_COEF_LO, 8'h00);
    rd(acxr_pkg::IDX_COEF_HI, 8'h40);
    rd(acxr_pkg::IDX_EXC_CTRL, {REV, 4'h0});
    rd(acxr_pkg::IDX_EXC_ROUTE, 8'hFF);
    rd(acxr_pkg::IDX_GPIO_EN, 8'h00);
    rd(acxr_pkg::IDX_GPIO_DIR, 8'h00);
    rd(6'h0F, 8'h00, acxr_pkg::RESP_SLVERR);
    wr(6'h0F, 8'h55, acxr_pkg::RESP_SLVERR);
    chk("routes", 32'h0, {12'h0, r1, r2});
    sdo <= 1'b1;
    res(24'h000064, 24'h000000, 24'h000064);
    chk("shared", 32'h1, {31'h0, shr});
    wr(acxr_pkg::IDX_EXC_CTRL, 8'h08);
    settle();
    chk("shared", 32'h0, {31'h0, shr});
    @(posedge clk);
    sact <= 1'b1;
    rrel <= 1'b1;
    @(posedge clk);
    rrel <= 1'b0;
    settle();
    chk("ready_n", 32'h1, {31'h0, rdy_n});
    // Internal reference taken as already on; its control lies outside this bank
    for (int i = 0; i < 8; i++) begin
      wr(acxr_pkg::IDX_EXC_CTRL, 8'(i));
      settle();
      chk("magnitude", 32'(i), {29'h0, mag});
      chk("current", {21'h0, uat[i]}, {21'h0, ua});
    end
    wr(acxr_pkg::IDX_EXC_CTRL, 8'hFF);
    rd(acxr_pkg::IDX_EXC_CTRL, {REV, 4'hF});
    for (int i = 0; i < 4; i++) begin
      wr(acxr_pkg::IDX_EXC_ROUTE, codes[i]);
      settle();
      chk("first", {22'h0, route(codes[i][7:4])}, {22'h0, r1});
      chk("second", {22'h0, route(codes[i][3:0])}, {22'h0, r2});
    end
    wr(acxr_pkg::IDX_GPIO_EN, 8'hFF);
    wr(acxr_pkg::IDX_GPIO_DIR, 8'h0F);
    wr(acxr_pkg::IDX_GPIO_DATA, 8'hA5);
    settle();
    chk("gpio_oe", 32'hF0, {24'h0, goe});
    chk("gpio_out", 32'hA5, {24'h0, gout});
    rd(acxr_pkg::IDX_GPIO_DATA, 8'hAC);
    wr(acxr_pkg::IDX_COEF_LO, 8'h02);
    wr(acxr_pkg::IDX_COEF_HI, 8'h20);
    rd(acxr_pkg::IDX_COEF_LO, 8'h02);
    res(24'h0003E8, 24'h0000C8, 24'h000190);
    close_out();
  end
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
